// ===== hw/timer_mode_pkg.sv
// Package with register map, field layout, mode codes and prescaler taps of the timer pair block.
package timer_mode_pkg;

  localparam int ADDR_WIDTH = 12;

  localparam logic [11:0] RUN_CONTROL_OFFSET = 12'h100;
  localparam logic [11:0] PAIR01_MODE_OFFSET = 12'h104;
  localparam logic [11:0] PAIR23_MODE_OFFSET = 12'h10c;
  localparam logic [11:0] COMPARE_OFFSET     = 12'h110;
  localparam logic [11:0] COUNT_OFFSET       = 12'h114;

  localparam int MODE_MSB      = 7;
  localparam int MODE_LSB      = 6;
  localparam int PWM_MSB       = 5;
  localparam int PWM_LSB       = 4;
  localparam int UPPER_SEL_MSB = 3;
  localparam int UPPER_SEL_LSB = 2;
  localparam int LOWER_SEL_MSB = 1;
  localparam int LOWER_SEL_LSB = 0;

  localparam logic [1:0] MODE_TWO_8BIT   = 2'h0;
  localparam logic [1:0] MODE_CASCADE_16 = 2'h1;
  localparam logic [1:0] MODE_PPG        = 2'h2;
  localparam logic [1:0] MODE_PWM        = 2'h3;

  localparam logic [1:0] PWM_CYCLE_2P6 = 2'h1;
  localparam logic [1:0] PWM_CYCLE_2P7 = 2'h2;
  localparam logic [7:0] PWM_MASK_2P6  = 8'h3f;
  localparam logic [7:0] PWM_MASK_2P7  = 8'h7f;
  localparam logic [7:0] PWM_MASK_2P8  = 8'hff;

  localparam logic [1:0] LOWER_SEL_EXT   = 2'h0;
  localparam logic [1:0] LOWER_SEL_DIV1  = 2'h1;
  localparam logic [1:0] LOWER_SEL_DIV4  = 2'h2;
  localparam logic [1:0] LOWER_SEL_DIV16 = 2'h3;
  localparam logic [1:0] UPPER_SEL_MATCH  = 2'h0;
  localparam logic [1:0] UPPER_SEL_DIV1   = 2'h1;
  localparam logic [1:0] UPPER_SEL_DIV16  = 2'h2;
  localparam logic [1:0] UPPER_SEL_DIV256 = 2'h3;

  localparam int PRESCALE_WIDTH = 9;
  localparam int TAP_DIV1_BIT   = 0;
  localparam int TAP_DIV4_BIT   = 2;
  localparam int TAP_DIV16_BIT  = 4;
  localparam int TAP_DIV256_BIT = 8;

  localparam int RUN_WIDTH        = 5;
  localparam int RUN_PRESCALE_BIT = 0;
  localparam int RUN_TIMER0_BIT   = 1;

  localparam logic [7:0]           MODE_RESET    = 8'h00;
  localparam logic [RUN_WIDTH-1:0] RUN_RESET     = 5'h00;
  localparam logic [31:0]          COMPARE_RESET = 32'h0000_0000;

endpackage : timer_mode_pkg

// ===== hw/timer_pair_counter_unit.sv
// One timer pair: count clock selection, two 8-bit counters, compare, cascade and PWM wrap.
`timescale 1ns/1ps
module timer_pair_counter_unit #(
  parameter logic HAS_EXT_INPUT = 1'b1
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] mode_control,
  input  wire logic       run_lower,
  input  wire logic       run_upper,
  input  wire logic       ext_tick,
  input  wire logic       tap_div1,
  input  wire logic       tap_div4,
  input  wire logic       tap_div16,
  input  wire logic       tap_div256,
  input  wire logic [7:0] compare_lower,
  input  wire logic [7:0] compare_upper,
  output logic      [7:0] count_lower,
  output logic      [7:0] count_upper,
  output logic            match_lower,
  output logic            match_upper,
  output logic            cycle_end
);
  import timer_mode_pkg::*;

  logic [1:0]  op_mode;
  logic [1:0]  sel_lower;
  logic [1:0]  sel_upper;
  logic        cascade;
  logic        tick_lower;
  logic        tick_upper;
  logic        hit_lower;
  logic        wrap_lower;
  logic [7:0]  wrap_mask;
  logic [7:0]  lower_inc;
  logic [7:0]  upper_inc;
  logic [15:0] pair_inc;
  logic [7:0]  count_lower_next;
  logic [7:0]  count_upper_next;
  logic        match_lower_next;
  logic        match_upper_next;
  logic        cycle_end_next;

  assign op_mode   = mode_control[MODE_MSB:MODE_LSB];
  assign sel_lower = mode_control[LOWER_SEL_MSB:LOWER_SEL_LSB];
  assign sel_upper = mode_control[UPPER_SEL_MSB:UPPER_SEL_LSB];
  assign lower_inc = count_lower + 8'h01;
  assign upper_inc = count_upper + 8'h01;
  assign pair_inc  = {count_upper, count_lower} + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cascade = (op_mode == MODE_CASCADE_16);
    case (sel_lower)
      LOWER_SEL_EXT:   tick_lower = HAS_EXT_INPUT & ext_tick;
      LOWER_SEL_DIV1:  tick_lower = tap_div1;
      LOWER_SEL_DIV4:  tick_lower = tap_div4;
      LOWER_SEL_DIV16: tick_lower = tap_div16;
      default:         tick_lower = 1'b0;
    endcase
    // The reserved cycle code runs the full 8-bit period so the counter never sticks.
    case (mode_control[PWM_MSB:PWM_LSB])
      PWM_CYCLE_2P6: wrap_mask = PWM_MASK_2P6;
      PWM_CYCLE_2P7: wrap_mask = PWM_MASK_2P7;
      default:       wrap_mask = PWM_MASK_2P8;
    endcase
    if (op_mode != MODE_PWM) begin
      wrap_mask = PWM_MASK_2P8;
    end
    wrap_lower = tick_lower && ((count_lower & wrap_mask) == wrap_mask);
    hit_lower  = tick_lower && !cascade && (lower_inc == compare_lower);
    if (cascade) begin
      tick_upper = wrap_lower;
    end else begin
      case (sel_upper)
        UPPER_SEL_MATCH:  tick_upper = hit_lower;
        UPPER_SEL_DIV1:   tick_upper = tap_div1;
        UPPER_SEL_DIV16:  tick_upper = tap_div16;
        UPPER_SEL_DIV256: tick_upper = tap_div256;
        default:          tick_upper = 1'b0;
      endcase
    end
  end

  always_comb begin
    count_lower_next = count_lower;
    count_upper_next = count_upper;
    match_lower_next = 1'b0;
    match_upper_next = 1'b0;
    cycle_end_next   = 1'b0;
    if (cascade) begin
      if (tick_lower) begin
        if (pair_inc == {compare_upper, compare_lower}) begin
          {count_upper_next, count_lower_next} = 16'h0000;
          match_upper_next = 1'b1;
        end else begin
          {count_upper_next, count_lower_next} = pair_inc;
        end
      end
    end else begin
      if (tick_lower) begin
        if (op_mode == MODE_PWM) begin
          // The compare only marks the duty point; the period is set by the wrap.
          count_lower_next = wrap_lower ? 8'h00 : lower_inc;
          match_lower_next = hit_lower;
          cycle_end_next   = wrap_lower;
        end else if (hit_lower) begin
          count_lower_next = 8'h00;
          match_lower_next = 1'b1;
        end else begin
          count_lower_next = lower_inc;
        end
      end
      if (tick_upper) begin
        if (upper_inc == compare_upper) begin
          count_upper_next = 8'h00;
          match_upper_next = 1'b1;
        end else begin
          count_upper_next = upper_inc;
        end
      end
    end
    if (!run_lower) begin
      count_lower_next = 8'h00;
      match_lower_next = 1'b0;
      cycle_end_next   = 1'b0;
    end
    if (!run_upper && !cascade) begin
      count_upper_next = 8'h00;
      match_upper_next = 1'b0;
    end
    if (!run_lower && cascade) begin
      count_upper_next = 8'h00;
      match_upper_next = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_lower <= 8'h00;
      count_upper <= 8'h00;
      match_lower <= 1'b0;
      match_upper <= 1'b0;
      cycle_end   <= 1'b0;
    end else begin
      count_lower <= count_lower_next;
      count_upper <= count_upper_next;
      match_lower <= match_lower_next;
      match_upper <= match_upper_next;
      cycle_end   <= cycle_end_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_cascade_carry: assert property (@(posedge hclk) disable iff (!hresetn)
    cascade && run_lower && tick_lower && count_lower == 8'hff && pair_inc != {compare_upper, compare_lower}
    |=> count_lower == 8'h00 && count_upper == 8'($past(count_upper) + 8'h01))
    else $error("cascaded upper counter missed a lower overflow");

  a_lower_div1_count: assert property (@(posedge hclk) disable iff (!hresetn)
    !cascade && op_mode != MODE_PWM && sel_lower == LOWER_SEL_DIV1 && run_lower && tap_div1 && !hit_lower
    |=> count_lower == 8'($past(count_lower) + 8'h01))
    else $error("lower counter did not advance on the divide-by-1 tap");

  a_lower_ext_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    sel_lower == LOWER_SEL_EXT && !ext_tick && run_lower && !cascade |=> $stable(count_lower))
    else $error("lower counter moved without an external edge");

  a_upper_div256_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !cascade && sel_upper == UPPER_SEL_DIV256 && run_upper && !tap_div256 |=> $stable(count_upper))
    else $error("upper counter moved without a divide-by-256 tick");

  a_upper_match_chain: assert property (@(posedge hclk) disable iff (!hresetn)
    !cascade && sel_upper == UPPER_SEL_MATCH && run_upper && hit_lower && run_lower && upper_inc != compare_upper
    |=> count_upper == 8'($past(count_upper) + 8'h01) && match_lower)
    else $error("upper counter did not follow the lower match");

  a_match_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    match_lower && $past(op_mode) != MODE_PWM |-> count_lower == 8'h00)
    else $error("lower match without clearing the counter");

  a_pwm_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    cycle_end |-> $past(op_mode) == MODE_PWM && count_lower == 8'h00
      && ($past(count_lower) & $past(wrap_mask)) == $past(wrap_mask))
    else $error("PWM cycle end at the wrong count");

endmodule : timer_pair_counter_unit

// ===== hw/timer_pair_mode_clock_select.sv
// Timer pair mode and clock select block with AHB-Lite register slave and shared 9-bit prescaler.
//
// Summary of operation
// - Mode field 7:6: 00 two 8-bit, 01 cascaded 16-bit, 10 PPG code (runs as two 8-bit), 11 PWM plus timer.
// - In cascaded mode the upper counter counts lower overflows, ignoring its select.
// - PWM cycle field 5:4 gives 2^6, 2^7, 2^8 periods; code 00 reserved.
// - Timer0 clock: 00 external pin, 01 divide-by-1, 10 divide-by-4, 11 divide-by-16.
// - Timer1 clock: 00 timer0 match, 01 div1, 10 div16, 11 div256 taps.
// - Timer2 clock: 01 div1, 10 div4, 11 div16; software never writes 00.
// - Timer3 clock: timer2 match, div1, div16, div256; cascaded counts timer2 overflow.
// - Taps come from a 9-bit prescaler that runs when enabled, cleared when not.
// - A compare match clears the counter (not timer0/timer2 in PWM mode, which wrap) and raises that timer's request.
`timescale 1ns/1ps
module timer_pair_mode_clock_select (
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic [31:0]                               hrdata,
  output logic                                      hresp,
  input  wire logic                                 timer0_external_input,
  output logic [3:0]                                timer_match_request,
  output logic [1:0]                                pwm_cycle_end
);
  import timer_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end.
  logic                  wr_pend_reg;
  logic                  wr_pend_next;
  logic [ADDR_WIDTH-1:0] addr_pend_reg;
  logic [ADDR_WIDTH-1:0] addr_pend_next;
  logic [31:0]           hrdata_next;
  logic                  access_taken;

  // Control registers.
  logic [7:0]            pair01_mode_control_reg;
  logic [7:0]            pair01_mode_control_next;
  logic [7:0]            pair23_mode_control_reg;
  logic [7:0]            pair23_mode_control_next;
  logic [RUN_WIDTH-1:0]  run_control_reg;
  logic [RUN_WIDTH-1:0]  run_control_next;
  logic [31:0]           compare_reg;
  logic [31:0]           compare_next;

  // Prescaler and external input.
  logic [PRESCALE_WIDTH-1:0] prescaler_reg;
  logic [PRESCALE_WIDTH-1:0] prescaler_next;
  logic [3:0]                tap_reg;
  logic [3:0]                tap_next;
  logic                      ext_sync1_reg;
  logic                      ext_sync2_reg;
  logic                      ext_last_reg;
  logic                      ext_tick;

  // Pair outputs.
  logic [7:0] count0;
  logic [7:0] count1;
  logic [7:0] count2;
  logic [7:0] count3;

  ////////////////////////////////////////////////////////////////////////////
  // The slave stalls only in reset (hreadyout low) and always answers OKAY; both are flops.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign access_taken = hready && hsel && htrans[1];

  always_comb begin
    wr_pend_next   = 1'b0;
    addr_pend_next = addr_pend_reg;
    if (hready) begin
      wr_pend_next   = access_taken && hwrite;
      addr_pend_next = haddr[ADDR_WIDTH-1:0];
    end else begin
      wr_pend_next   = wr_pend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes land at the end of the data phase. Read data is muxed from the
  // next values, so a read straight after a write to the same register sees the new data.
  always_comb begin
    pair01_mode_control_next = pair01_mode_control_reg;
    pair23_mode_control_next = pair23_mode_control_reg;
    run_control_next         = run_control_reg;
    compare_next             = compare_reg;
    if (wr_pend_reg) begin
      case ({addr_pend_reg[ADDR_WIDTH-1:2], 2'b00})
        RUN_CONTROL_OFFSET: run_control_next         = hwdata[RUN_WIDTH-1:0];
        PAIR01_MODE_OFFSET: pair01_mode_control_next = hwdata[7:0];
        PAIR23_MODE_OFFSET: pair23_mode_control_next = hwdata[7:0];
        COMPARE_OFFSET:     compare_next             = hwdata;
        default:            compare_next             = compare_reg;
      endcase
    end
  end

  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (access_taken && !hwrite) begin
      case ({haddr[ADDR_WIDTH-1:2], 2'b00})
        RUN_CONTROL_OFFSET: hrdata_next = {27'h0000000, run_control_next};
        PAIR01_MODE_OFFSET: hrdata_next = {24'h000000, pair01_mode_control_next};
        PAIR23_MODE_OFFSET: hrdata_next = {24'h000000, pair23_mode_control_next};
        COMPARE_OFFSET:     hrdata_next = compare_next;
        COUNT_OFFSET:       hrdata_next = {count3, count2, count1, count0};
        default:            hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg             <= 1'b0;
      addr_pend_reg           <= '0;
      hrdata                  <= 32'h0000_0000;
      pair01_mode_control_reg <= MODE_RESET;
      pair23_mode_control_reg <= MODE_RESET;
      run_control_reg         <= RUN_RESET;
      compare_reg             <= COMPARE_RESET;
    end else begin
      wr_pend_reg             <= wr_pend_next;
      addr_pend_reg           <= addr_pend_next;
      hrdata                  <= hrdata_next;
      pair01_mode_control_reg <= pair01_mode_control_next;
      pair23_mode_control_reg <= pair23_mode_control_next;
      run_control_reg         <= run_control_next;
      compare_reg             <= compare_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Taps are one-cycle pulses on each rising transition of the chosen prescaler bit.
  always_comb begin
    if (run_control_reg[RUN_PRESCALE_BIT]) begin
      prescaler_next = prescaler_reg + 9'h001;
    end else begin
      prescaler_next = 9'h000;
    end
    tap_next[0] = !prescaler_reg[TAP_DIV1_BIT] && prescaler_next[TAP_DIV1_BIT];
    tap_next[1] = !prescaler_reg[TAP_DIV4_BIT] && prescaler_next[TAP_DIV4_BIT];
    tap_next[2] = !prescaler_reg[TAP_DIV16_BIT] && prescaler_next[TAP_DIV16_BIT];
    tap_next[3] = !prescaler_reg[TAP_DIV256_BIT] && prescaler_next[TAP_DIV256_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler_reg <= 9'h000;
      tap_reg       <= 4'h0;
    end else begin
      prescaler_reg <= prescaler_next;
      tap_reg       <= tap_next;
    end
  end

  // The pin is asynchronous; the edge detector reads only the second stage and later.
  assign ext_tick = ext_sync2_reg && !ext_last_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_last_reg  <= 1'b0;
    end else begin
      ext_sync1_reg <= timer0_external_input;
      ext_sync2_reg <= ext_sync1_reg;
      ext_last_reg  <= ext_sync2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  timer_pair_counter_unit #(
    .HAS_EXT_INPUT (1'b1)
  ) u_pair01 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .mode_control  (pair01_mode_control_reg),
    .run_lower     (run_control_reg[RUN_TIMER0_BIT]),
    .run_upper     (run_control_reg[RUN_TIMER0_BIT+1]),
    .ext_tick      (ext_tick),
    .tap_div1      (tap_reg[0]),
    .tap_div4      (tap_reg[1]),
    .tap_div16     (tap_reg[2]),
    .tap_div256    (tap_reg[3]),
    .compare_lower (compare_reg[7:0]),
    .compare_upper (compare_reg[15:8]),
    .count_lower   (count0),
    .count_upper   (count1),
    .match_lower   (timer_match_request[0]),
    .match_upper   (timer_match_request[1]),
    .cycle_end     (pwm_cycle_end[0])
  );

  // Timer2 has no external pin, so select code 00 leaves it stopped.
  timer_pair_counter_unit #(
    .HAS_EXT_INPUT (1'b0)
  ) u_pair23 (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .mode_control  (pair23_mode_control_reg),
    .run_lower     (run_control_reg[RUN_TIMER0_BIT+2]),
    .run_upper     (run_control_reg[RUN_TIMER0_BIT+3]),
    .ext_tick      (1'b0),
    .tap_div1      (tap_reg[0]),
    .tap_div4      (tap_reg[1]),
    .tap_div16     (tap_reg[2]),
    .tap_div256    (tap_reg[3]),
    .compare_lower (compare_reg[23:16]),
    .compare_upper (compare_reg[31:24]),
    .count_lower   (count2),
    .count_upper   (count3),
    .match_lower   (timer_match_request[2]),
    .match_upper   (timer_match_request[3]),
    .cycle_end     (pwm_cycle_end[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  a_reset_mode_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(hresetn) |-> pair01_mode_control_reg == 8'h00 && pair23_mode_control_reg == 8'h00)
    else $error("mode registers not clear after reset");

  a_mode_write_back: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_reg && {addr_pend_reg[ADDR_WIDTH-1:2], 2'b00} == PAIR23_MODE_OFFSET
    |=> pair23_mode_control_reg == $past(hwdata[7:0]))
    else $error("mode register write did not land");

  a_prescale_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    !run_control_reg[RUN_PRESCALE_BIT] |=> prescaler_reg == 9'h000 && tap_reg == 4'h0)
    else $error("prescaler not cleared while stopped");

  a_prescale_step: assert property (@(posedge hclk) disable iff (!hresetn)
    run_control_reg[RUN_PRESCALE_BIT] |=> prescaler_reg == 9'($past(prescaler_reg) + 9'h001))
    else $error("prescaler did not step while running");

  a_tap_div4_space: assert property (@(posedge hclk) disable iff (!hresetn)
    tap_reg[1] |=> !tap_reg[1] [*3])
    else $error("divide-by-4 tap closer than four cycles");

  a_mode_cascade: assert property (@(posedge hclk) disable iff (!hresetn)
    pair01_mode_control_reg[MODE_MSB:MODE_LSB] == MODE_CASCADE_16 throughout
      (run_control_reg[RUN_TIMER0_BIT] ##1 run_control_reg[RUN_TIMER0_BIT])
    |-> !timer_match_request[0])
    else $error("cascaded pair raised a lower match");

endmodule : timer_pair_mode_clock_select

// ===== tb/tb.sv
// Self-checking testbench for the timer pair mode and clock select block.
`timescale 1ns/1ps
module tb;
  import timer_mode_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        timer0_external_input;
  logic [3:0]  timer_match_request;
  logic [1:0]  pwm_cycle_end;
  logic [2:0]  pin_cnt;
  logic [5:0]  evt;
  logic [31:0] rd;
  int          error_cnt;
  int          cmp_count;
  int          s;

  timer_pair_mode_clock_select timer_pair_mode_clock_select_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .timer0_external_input(timer0_external_input),
    .timer_match_request(timer_match_request), .pwm_cycle_end(pwm_cycle_end));

  assign evt = {pwm_cycle_end, timer_match_request};

  always #2.5 hclk = ~hclk;

  // The pin toggles every four cycles, so a rising edge arrives every eight.
  always @(posedge hclk) begin
    pin_cnt               <= pin_cnt + 3'h1;
    timer0_external_input <= pin_cnt[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task chk_per(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_per

  task bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus_wr

  task bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : bus_rd

  // Measures the spacing of two consecutive pulses so the start-up phase does not matter.
  task sel_case(input logic [11:0] a, input logic [7:0] mode, input logic [4:0] run, input int b, input int exp);
    int n;
    bus_wr(12'h100, 32'h0);
    bus_wr(12'h110, 32'h0203_0203);
    bus_wr(a, {24'h0, mode});
    bus_wr(12'h100, {27'h0, run});
    n = 0;
    while (evt[b] !== 1'b1 && n < 4000) begin
      @(posedge hclk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (evt[b] !== 1'b1 && n < 4000);
    chk_per("event period", exp, n);
  endtask : sel_case

  task reg_access;
    bus_rd(PAIR01_MODE_OFFSET, rd);
    chk_val("pair01 reset", 32'h0, rd);
    bus_rd(PAIR23_MODE_OFFSET, rd);
    chk_val("pair23 reset", 32'h0, rd);
    bus_wr(PAIR01_MODE_OFFSET, 32'hffff_ff5a);
    bus_wr(PAIR23_MODE_OFFSET, 32'h0000_00a5);
    bus_rd(PAIR01_MODE_OFFSET, rd);
    chk_val("pair01 data", 32'h5a, rd);
    bus_rd(PAIR23_MODE_OFFSET, rd);
    chk_val("pair23 data", 32'ha5, rd);
    bus_wr(12'h108, 32'hffff_ffff);
    bus_rd(12'h108, rd);
    chk_val("unmapped", 32'h0, rd);
    bus_rd(COUNT_OFFSET, rd);
    chk_val("stopped counts", 32'h0, rd);
    chk_val("response", 32'h0, {31'h0, hresp});
  endtask : reg_access

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pin_cnt = 3'h0;
    timer0_external_input = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reg_access;
    sel_case(12'h104, 8'h00, 5'h03, 0, 24);
    for (s = 1; s < 4; s++) begin
      sel_case(12'h104, 8'(s), 5'h03, 0, 3 * (2 << (2 * (s - 1))));
      sel_case(12'h10c, 8'(s), 5'h09, 2, 3 * (2 << (2 * (s - 1))));
      sel_case(12'h104, 8'h01 | 8'(s << 2), 5'h07, 1, 2 * (2 << (4 * (s - 1))));
      sel_case(12'h10c, 8'h01 | 8'(s << 2), 5'h19, 3, 2 * (2 << (4 * (s - 1))));
      sel_case(12'h104, 8'hc1 | 8'(s << 4), 5'h03, 4, 2 << (5 + s));
      sel_case(12'h10c, 8'hc1 | 8'(s << 4), 5'h09, 5, 2 << (5 + s));
    end
    sel_case(12'h104, 8'h01, 5'h07, 1, 12);
    sel_case(12'h10c, 8'h01, 5'h19, 3, 12);
    sel_case(12'h104, 8'h45, 5'h03, 1, 1030);
    sel_case(12'h10c, 8'h45, 5'h09, 3, 1030);
    sel_case(12'h104, 8'h81, 5'h03, 0, 6);
    complete_run;
  end

  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end
endmodule : tb
